// ===== inc/fifo_reset_defs.svh
// Constants for the dual FIFO reset and configuration block.
// Included by the interface, both ends and the bench; definitions only.
`ifndef FIFO_RESET_DEFS_SVH
`define FIFO_RESET_DEFS_SVH

`define RST_MIN_EDGES 3'h4
`define RST_CNT_W 3
`define READY_DELAY 2'h2
`define OFFSET_W 10
`define OFFSET_CLEAR 10'h000
`define PAR_LOAD_WORDS 3'h4
`define HOLD_CYCLES 4'h6

`endif

// ===== inc/fifo_reset_pkg.sv
// Types shared by the device end and the bench.
// Assumes fifo_reset_defs.svh is compiled alongside.
package fifo_reset_pkg;
    typedef enum logic [1:0] {
        PROG_PRESET,
        PROG_PARALLEL,
        PROG_SERIAL,
        PROG_ILLEGAL
    } prog_method_t;

    typedef enum logic {
        ENDIAN_LITTLE,
        ENDIAN_BIG
    } endian_t;
endpackage

// ===== inc/fifo_reset_if.sv
// Reset and flag wiring between the controller and the dual FIFO device.
// Assumes one shared clock; all reset lines are active low levels.
`timescale 1ns/100ps
`include "fifo_reset_defs.svh"

interface fifo_reset_if;
    logic full_reset_fifo_one_n;
    logic full_reset_fifo_two_n;
    logic partial_reset_fifo_one_n;
    logic partial_reset_fifo_two_n;
    logic endian_select;
    logic flag_select_low;
    logic flag_select_high;
    logic serial_program_mode_n;
    logic port_a_write;
    logic [`OFFSET_W-1:0] port_a_data;
    logic port_a_full_or_input_ready;
    logic port_b_full_or_input_ready;
    logic port_a_empty_or_output_ready;
    logic port_b_empty_or_output_ready;
    logic port_a_almost_empty_n;
    logic port_b_almost_empty_n;
    logic port_a_almost_full_n;
    logic port_b_almost_full_n;
    logic mailbox_one_flag_n;
    logic mailbox_two_flag_n;

    modport device (
        input full_reset_fifo_one_n,
        input full_reset_fifo_two_n,
        input partial_reset_fifo_one_n,
        input partial_reset_fifo_two_n,
        input endian_select,
        input flag_select_low,
        input flag_select_high,
        input serial_program_mode_n,
        input port_a_write,
        input port_a_data,
        output port_a_full_or_input_ready,
        output port_b_full_or_input_ready,
        output port_a_empty_or_output_ready,
        output port_b_empty_or_output_ready,
        output port_a_almost_empty_n,
        output port_b_almost_empty_n,
        output port_a_almost_full_n,
        output port_b_almost_full_n,
        output mailbox_one_flag_n,
        output mailbox_two_flag_n
    );

    modport controller (
        output full_reset_fifo_one_n,
        output full_reset_fifo_two_n,
        output partial_reset_fifo_one_n,
        output partial_reset_fifo_two_n,
        output endian_select,
        output flag_select_low,
        output flag_select_high,
        output serial_program_mode_n,
        output port_a_write,
        output port_a_data,
        input port_a_full_or_input_ready,
        input port_b_full_or_input_ready,
        input port_a_empty_or_output_ready,
        input port_b_empty_or_output_ready,
        input port_a_almost_empty_n,
        input port_b_almost_empty_n,
        input port_a_almost_full_n,
        input port_b_almost_full_n,
        input mailbox_one_flag_n,
        input mailbox_two_flag_n
    );
endinterface

// ===== src/fifo_reset_device.sv
// Reset sequencing and configuration capture for a pair of opposed FIFOs.
// Assumes reset pins arrive from outside the clock domain and port clocks
// are represented by the single clk; the controller obeys the hold time.
//
// How it works
// - Controller full-resets both FIFOs after power-up
// - Controller holds full reset seven edges
// - Full resets accepted asynchronously at any time
// - Full reset clears pointers and drives flags
// - Full reset forces mailbox flag high
// - Input-ready rises five cycles after release; parallel mode holds port B until offsets load
// - First full-reset rise latches endian select
// - Same rise latches flag selects, program mode
// - Second full-reset rise clears its offsets
// - Shared rise latches config; controller releases together
// - Partial reset held seven edges, asynchronous
// - Partial reset clears pointers and drives flags
// - Partial reset forces mailbox flag high
// - Partial reset keeps offsets, method, mode
// - Reset assertion drives mirrored flags immediately
// - Endian high selects big, low little
// - Parallel mode: first four writes load offsets
`timescale 1ns/100ps
`include "fifo_reset_defs.svh"

module fifo_reset_device (
    input wire logic clk,
    input wire logic sys_rst,
    fifo_reset_if.device link,
    output fifo_reset_pkg::endian_t endian_mode,
    output fifo_reset_pkg::prog_method_t prog_method,
    output logic [1:0] flag_select,
    output logic [`OFFSET_W-1:0] fifo_one_almost_empty_offset,
    output logic [`OFFSET_W-1:0] fifo_one_almost_full_offset,
    output logic [`OFFSET_W-1:0] fifo_two_almost_empty_offset,
    output logic [`OFFSET_W-1:0] fifo_two_almost_full_offset,
    output logic [1:0] write_pointer_zero,
    output logic offsets_loaded
);
    // ------------------------------------------------------------
    // Per-FIFO reset sequencing
    // ------------------------------------------------------------
    logic [1:0] full_n_raw;
    logic [1:0] part_n_raw;
    logic [1:0] ready_q;
    logic par_busy;
    logic [1:0] async_hold;
    logic [1:0] in_reset;
    logic [1:0] full_rise;

    assign full_n_raw = {link.full_reset_fifo_two_n, link.full_reset_fifo_one_n};
    assign part_n_raw = {link.partial_reset_fifo_two_n, link.partial_reset_fifo_one_n};
    // Raw pins force flags with no clock, so a stopped clock still resets
    assign async_hold = ~(full_n_raw & part_n_raw);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_fifo
            logic [`RST_CNT_W-1:0] low_cnt_q;
            logic [1:0] wait_q;
            logic armed_q;
            logic full_s1_q;
            logic full_s2_q;
            logic part_s1_q;
            logic part_s2_q;
            logic full_prev_q;
            logic ready_bit_q;

            // Two-flop synchronisers; only the second stage is read.
            // Reset to the idle high level, so no false release follows sys_rst
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    full_s1_q <= 1'b1;
                    full_s2_q <= 1'b1;
                    part_s1_q <= 1'b1;
                    part_s2_q <= 1'b1;
                    full_prev_q <= 1'b1;
                end else begin
                    full_s1_q <= full_n_raw[g];
                    full_s2_q <= full_s1_q;
                    part_s1_q <= part_n_raw[g];
                    part_s2_q <= part_s1_q;
                    full_prev_q <= full_s2_q;
                end
            end

            assign in_reset[g] = ~full_s2_q | ~part_s2_q;
            assign full_rise[g] = full_s2_q & ~full_prev_q;
            assign ready_q[g] = ready_bit_q;

            // Count low edges; a short pulse never arms the release
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    low_cnt_q <= '0;
                    armed_q <= 1'b0;
                    wait_q <= '0;
                    ready_bit_q <= 1'b0;
                end else if (in_reset[g]) begin
                    ready_bit_q <= 1'b0;
                    wait_q <= '0;
                    if (low_cnt_q != `RST_MIN_EDGES) begin
                        low_cnt_q <= low_cnt_q + 1'b1;
                    end else begin
                        armed_q <= 1'b1;
                    end
                end else begin
                    low_cnt_q <= '0;
                    if (armed_q && wait_q != `READY_DELAY) begin
                        wait_q <= wait_q + 1'b1;
                    end else if (armed_q) begin
                        ready_bit_q <= 1'b1;
                        armed_q <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Flag outputs
    // ------------------------------------------------------------
    // Index 0 is fifo one (A to B), index 1 is fifo two (B to A)
    logic [1:0] hold;
    assign hold = async_hold | in_reset;
    assign link.port_a_full_or_input_ready = ready_q[0] & ~hold[0];
    assign link.port_b_full_or_input_ready = ready_q[1] & ~hold[1] & ~par_busy;
    assign link.port_b_empty_or_output_ready = 1'b0;
    assign link.port_a_empty_or_output_ready = 1'b0;
    assign link.port_b_almost_empty_n = 1'b0;
    assign link.port_a_almost_empty_n = 1'b0;
    // Almost-full and mailbox are high in and after reset; no data path here
    assign link.port_a_almost_full_n = 1'b1;
    assign link.port_b_almost_full_n = 1'b1;
    assign link.mailbox_one_flag_n = 1'b1;
    assign link.mailbox_two_flag_n = 1'b1;
    assign write_pointer_zero = hold | ~ready_q;

    // ------------------------------------------------------------
    // Configuration capture on full-reset release
    // ------------------------------------------------------------
    // Pins sampled through synchronisers aligned with the reset release
    logic [3:0] cfg_s1_q;
    logic [3:0] cfg_s2_q;
    logic [3:0] cfg_raw;
    fifo_reset_pkg::prog_method_t method_d;
    logic par_write;
    logic [2:0] par_idx_q;

    assign cfg_raw = {link.serial_program_mode_n, link.flag_select_high,
                      link.flag_select_low, link.endian_select};
    assign method_d = (cfg_s2_q[3] && cfg_s2_q[2:1] != 2'b00) ? fifo_reset_pkg::PROG_PRESET :
                      (cfg_s2_q[3]) ? fifo_reset_pkg::PROG_PARALLEL :
                      fifo_reset_pkg::PROG_SERIAL;
    assign par_busy = (prog_method == fifo_reset_pkg::PROG_PARALLEL) && !offsets_loaded;
    assign par_write = par_busy && ready_q[0] && !hold[0] && link.port_a_write;

    // Capture pins: slow setup vs. release, so two flops align them
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_s1_q <= '0;
            cfg_s2_q <= '0;
        end else begin
            cfg_s1_q <= cfg_raw;
            cfg_s2_q <= cfg_s1_q;
        end
    end

    // Latch mode on fifo one release; partial resets leave it alone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            endian_mode <= fifo_reset_pkg::ENDIAN_LITTLE;
            prog_method <= fifo_reset_pkg::PROG_PRESET;
            flag_select <= 2'b00;
        end else if (full_rise[0]) begin
            endian_mode <= fifo_reset_pkg::endian_t'(cfg_s2_q[0]);
            prog_method <= method_d;
            flag_select <= cfg_s2_q[2:1];
        end
    end

    // Offset registers: cleared by full release, loaded in parallel mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fifo_one_almost_empty_offset <= `OFFSET_CLEAR;
            fifo_one_almost_full_offset <= `OFFSET_CLEAR;
            fifo_two_almost_empty_offset <= `OFFSET_CLEAR;
            fifo_two_almost_full_offset <= `OFFSET_CLEAR;
            par_idx_q <= '0;
            offsets_loaded <= 1'b0;
        end else begin
            if (full_rise[0]) begin
                fifo_one_almost_empty_offset <= `OFFSET_CLEAR;
                fifo_one_almost_full_offset <= `OFFSET_CLEAR;
                par_idx_q <= '0;
                offsets_loaded <= 1'b0;
            end
            if (full_rise[1]) begin
                fifo_two_almost_empty_offset <= `OFFSET_CLEAR;
                fifo_two_almost_full_offset <= `OFFSET_CLEAR;
            end
            if (!full_rise[0] && par_write) begin
                // Order: fifo one full, one empty, two full, two empty
                case (par_idx_q[1:0])
                    2'h0: fifo_one_almost_full_offset <= link.port_a_data;
                    2'h1: fifo_one_almost_empty_offset <= link.port_a_data;
                    2'h2: fifo_two_almost_full_offset <= link.port_a_data;
                    2'h3: fifo_two_almost_empty_offset <= link.port_a_data;
                    default: fifo_one_almost_full_offset <= link.port_a_data;
                endcase
                par_idx_q <= par_idx_q + 1'b1;
                if (par_idx_q + 1'b1 == `PAR_LOAD_WORDS) begin
                    offsets_loaded <= 1'b1;
                end
            end else if (!full_rise[0] && prog_method != fifo_reset_pkg::PROG_PARALLEL) begin
                offsets_loaded <= 1'b1;
            end
        end
    end
endmodule

// ===== src/fifo_reset_controller.sv
// Controller end: sequences full and partial resets of the FIFO pair.
// Assumes requests come from logic on clk; configuration held by the user.
`timescale 1ns/100ps
`include "fifo_reset_defs.svh"

module fifo_reset_controller (
    input wire logic clk,
    input wire logic sys_rst,
    fifo_reset_if.controller link,
    input wire logic full_req,
    input wire logic [1:0] partial_req,
    input wire logic cfg_endian,
    input wire logic [1:0] cfg_flag_select,
    input wire logic cfg_serial_n,
    input wire logic wr_req,
    input wire logic [`OFFSET_W-1:0] wr_data,
    output logic busy,
    output logic [1:0] fifo_ready
);
    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_FULL,
        ST_PART
    } ctl_state_t;

    ctl_state_t state_q;
    logic [3:0] cnt_q;
    logic [1:0] part_sel_q;
    logic done;

    // Extra margin over four edges covers the device synchroniser
    assign done = (cnt_q == `HOLD_CYCLES);
    assign busy = (state_q != ST_IDLE);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_POWERUP;
            cnt_q <= '0;
            part_sel_q <= '0;
        end else begin
            case (state_q)
                // First act after power-up is a joint full reset
                ST_POWERUP: begin
                    state_q <= ST_FULL;
                    cnt_q <= '0;
                end
                ST_IDLE: begin
                    cnt_q <= '0;
                    if (full_req) begin
                        state_q <= ST_FULL;
                    end else if (partial_req != 2'b00) begin
                        part_sel_q <= partial_req;
                        state_q <= ST_PART;
                    end
                end
                ST_FULL, ST_PART: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_POWERUP;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    // Both full resets share one level so they release together
    assign link.full_reset_fifo_one_n = (state_q != ST_FULL);
    assign link.full_reset_fifo_two_n = (state_q != ST_FULL);
    assign link.partial_reset_fifo_one_n = !(state_q == ST_PART && part_sel_q[0]);
    assign link.partial_reset_fifo_two_n = !(state_q == ST_PART && part_sel_q[1]);
    // Config pins held static across the release edge
    assign link.endian_select = cfg_endian;
    assign link.flag_select_low = cfg_flag_select[0];
    assign link.flag_select_high = cfg_flag_select[1];
    assign link.serial_program_mode_n = cfg_serial_n;
    assign link.port_a_write = wr_req && !busy && link.port_a_full_or_input_ready;
    assign link.port_a_data = wr_data;
    assign fifo_ready = {link.port_b_full_or_input_ready, link.port_a_full_or_input_ready};
endmodule

// ===== bench/fifo_reset_checker.sv
// Concurrent checks on the reset and flag wiring between the two ends.
// Assumes one clock domain; instantiated beside the interface by the bench.
`timescale 1ns/100ps

module fifo_reset_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic full_reset_fifo_one_n,
    input wire logic full_reset_fifo_two_n,
    input wire logic partial_reset_fifo_one_n,
    input wire logic partial_reset_fifo_two_n,
    input wire logic port_a_full_or_input_ready,
    input wire logic port_b_full_or_input_ready,
    input wire logic port_a_empty_or_output_ready,
    input wire logic port_b_empty_or_output_ready,
    input wire logic port_a_almost_empty_n,
    input wire logic port_b_almost_empty_n,
    input wire logic port_a_almost_full_n,
    input wire logic port_b_almost_full_n,
    input wire logic mailbox_one_flag_n,
    input wire logic mailbox_two_flag_n
);
    // -------------------------------------------
    // Flag and timing properties
    // -------------------------------------------
    // Short names keep the properties readable
    wire logic one_ok = full_reset_fifo_one_n && partial_reset_fifo_one_n;
    wire logic two_ok = full_reset_fifo_two_n && partial_reset_fifo_two_n;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_one_rst_flags: assert property (!one_ok |->
        !port_a_full_or_input_ready && !port_a_empty_or_output_ready)
        else $error("fifo one flags not cleared in reset");
    a_two_rst_flags: assert property (!two_ok |->
        !port_b_full_or_input_ready && !port_b_empty_or_output_ready)
        else $error("fifo two flags not cleared in reset");
    a_one_async_flags: assert property (!one_ok |->
        !port_b_almost_empty_n && port_a_almost_full_n && mailbox_one_flag_n)
        else $error("fifo one mirrored flags wrong in reset");
    a_two_async_flags: assert property (!two_ok |->
        !port_a_almost_empty_n && port_b_almost_full_n && mailbox_two_flag_n)
        else $error("fifo two mirrored flags wrong in reset");
    // Ready may only rise after two clean cycles past release
    a_a_not_early: assert property ($rose(port_a_full_or_input_ready) |->
        $past(one_ok, 1) && $past(one_ok, 2))
        else $error("port a ready rose too soon");
    a_b_not_early: assert property ($rose(port_b_full_or_input_ready) |->
        $past(two_ok, 1) && $past(two_ok, 2))
        else $error("port b ready rose too soon");
    a_ready_bounded: assert property ($rose(one_ok) |->
        ##[1:8] (port_a_full_or_input_ready || !one_ok))
        else $error("port a ready late after release");
    a_ready_holds: assert property (port_a_full_or_input_ready && one_ok |=>
        port_a_full_or_input_ready || !one_ok)
        else $error("port a ready dropped without reset");
    a_full_hold: assert property ($fell(full_reset_fifo_one_n) |->
        !full_reset_fifo_one_n [*4])
        else $error("full reset pulse too short");
    a_full_pair: assert property ($rose(full_reset_fifo_one_n) |->
        $rose(full_reset_fifo_two_n))
        else $error("full resets not released together");
endmodule

// ===== bench/dual_fifo_reset_config_bench.sv
// Bench for the controller and device joined through the reset interface.
// Assumes the shared defines header and package are compiled first.
`timescale 1ns/100ps
`include "fifo_reset_defs.svh"

module dual_fifo_reset_config_bench;
    typedef struct {
        logic endian;
        logic [1:0] fs;
        logic spm_n;
        fifo_reset_pkg::prog_method_t method;
    } case_row_t;
    logic clk;
    logic sys_rst;
    logic full_req;
    logic [1:0] partial_req;
    logic cfg_endian;
    logic [1:0] cfg_flag_select;
    logic cfg_serial_n;
    logic wr_req;
    logic [`OFFSET_W-1:0] wr_data;
    logic busy;
    logic [1:0] fifo_ready;
    fifo_reset_pkg::endian_t endian_mode;
    fifo_reset_pkg::prog_method_t prog_method;
    logic [1:0] flag_select;
    logic [`OFFSET_W-1:0] one_ae, one_af, two_ae, two_af;
    logic [1:0] write_pointer_zero;
    logic offsets_loaded;
    logic par;
    int fail_count = 0;
    int checks_done = 0;
    int cycle_count = 0;
    case_row_t rows [5];

    // -------------------------------------------
    // Design under test
    // -------------------------------------------
    fifo_reset_if link ();
    fifo_reset_controller fifo_reset_controller_inst (.clk(clk), .sys_rst(sys_rst),
        .link(link), .full_req(full_req), .partial_req(partial_req),
        .cfg_endian(cfg_endian), .cfg_flag_select(cfg_flag_select),
        .cfg_serial_n(cfg_serial_n), .wr_req(wr_req), .wr_data(wr_data),
        .busy(busy), .fifo_ready(fifo_ready));
    fifo_reset_device fifo_reset_device_inst (.clk(clk), .sys_rst(sys_rst), .link(link),
        .endian_mode(endian_mode), .prog_method(prog_method), .flag_select(flag_select),
        .fifo_one_almost_empty_offset(one_ae), .fifo_one_almost_full_offset(one_af),
        .fifo_two_almost_empty_offset(two_ae), .fifo_two_almost_full_offset(two_af),
        .write_pointer_zero(write_pointer_zero), .offsets_loaded(offsets_loaded));
    fifo_reset_checker fifo_reset_checker_inst (.clk(clk), .sys_rst(sys_rst),
        .full_reset_fifo_one_n(link.full_reset_fifo_one_n),
        .full_reset_fifo_two_n(link.full_reset_fifo_two_n),
        .partial_reset_fifo_one_n(link.partial_reset_fifo_one_n),
        .partial_reset_fifo_two_n(link.partial_reset_fifo_two_n),
        .port_a_full_or_input_ready(link.port_a_full_or_input_ready),
        .port_b_full_or_input_ready(link.port_b_full_or_input_ready),
        .port_a_empty_or_output_ready(link.port_a_empty_or_output_ready),
        .port_b_empty_or_output_ready(link.port_b_empty_or_output_ready),
        .port_a_almost_empty_n(link.port_a_almost_empty_n),
        .port_b_almost_empty_n(link.port_b_almost_empty_n),
        .port_a_almost_full_n(link.port_a_almost_full_n),
        .port_b_almost_full_n(link.port_b_almost_full_n),
        .mailbox_one_flag_n(link.mailbox_one_flag_n),
        .mailbox_two_flag_n(link.mailbox_two_flag_n));

    // -------------------------------------------
    // Clock, hang guard and helpers
    // -------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run is well under a thousand cycles
    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count == 3000) begin
            fail_count++;
            finish_test;
        end
    end

    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task chk_m(input string what, input fifo_reset_pkg::prog_method_t exp,
               input fifo_reset_pkg::prog_method_t got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait; sampling 1 ns past the edge avoids edge races
    task wait_ready(input logic [1:0] m);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        #1;
        while (((fifo_ready & m) !== m || busy !== 1'b0) && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("ready", {8'h00, m}, {8'h00, fifo_ready & m});
    endtask

    task request(input logic full, input logic [1:0] part);
        @(posedge clk);
        full_req <= full;
        partial_req <= part;
        @(posedge clk);
        full_req <= 1'b0;
        partial_req <= 2'h0;
        #1;
    endtask

    task set_cfg(input logic e, input logic [1:0] fs, input logic sn);
        @(posedge clk);
        cfg_endian <= e;
        cfg_flag_select <= fs;
        cfg_serial_n <= sn;
    endtask

    // Settings and offsets from the parallel load must survive
    task check_kept;
        chk("endian", 10'h001, {9'h000, endian_mode});
        chk_m("method", fifo_reset_pkg::PROG_PARALLEL, prog_method);
        chk("offsets", 10'h011, one_af);
        chk("offsets", 10'h022, one_ae);
        chk("offsets", 10'h033, two_af);
        chk("offsets", 10'h3ff, two_ae);
    endtask

    // -------------------------------------------
    // Main sequence
    // -------------------------------------------
    initial begin
        rows[0] = '{1'b1, 2'h3, 1'b1, fifo_reset_pkg::PROG_PRESET};
        rows[1] = '{1'b0, 2'h1, 1'b1, fifo_reset_pkg::PROG_PRESET};
        rows[2] = '{1'b0, 2'h2, 1'b1, fifo_reset_pkg::PROG_PRESET};
        rows[3] = '{1'b1, 2'h2, 1'b0, fifo_reset_pkg::PROG_SERIAL};
        rows[4] = '{1'b1, 2'h0, 1'b1, fifo_reset_pkg::PROG_PARALLEL};
        sys_rst = 1'b1;
        full_req = 1'b0;
        partial_req = 2'h0;
        cfg_endian = 1'b0;
        cfg_flag_select = 2'h1;
        cfg_serial_n = 1'b1;
        wr_req = 1'b0;
        wr_data = 10'h000;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("power-up full resets", 10'h000,
            {8'h00, link.full_reset_fifo_one_n, link.full_reset_fifo_two_n});
        wait_ready(2'h1);
        // Configuration table, one full reset per row
        foreach (rows[i]) begin
            set_cfg(rows[i].endian, rows[i].fs, rows[i].spm_n);
            par = (rows[i].method == fifo_reset_pkg::PROG_PARALLEL);
            request(1'b1, 2'h0);
            chk("ready in reset", 10'h000, {8'h00, fifo_ready});
            wait_ready(par ? 2'h1 : 2'h3);
            chk("endian", {9'h000, rows[i].endian}, {9'h000, endian_mode});
            chk_m("method", rows[i].method, prog_method);
            chk("flag select", {8'h00, rows[i].fs}, {8'h00, flag_select});
            chk("port b ready", {9'h000, !par}, {9'h000, fifo_ready[1]});
        end
        chk("fifo two offsets", 10'h000, two_ae | two_af);
        // Parallel load, largest value last
        foreach (rows[k]) begin
            if (k < 4) begin
                @(posedge clk);
                wr_req <= 1'b1;
                wr_data <= (k == 3) ? 10'h3ff : 10'(8'h11 * (k + 1));
                @(posedge clk);
                wr_req <= 1'b0;
            end
        end
        repeat (2) @(posedge clk);
        #1;
        check_kept;
        chk("loaded", 10'h003, {8'h00, offsets_loaded, fifo_ready[1]});
        // Partial resets with new pins: nothing may be relatched
        set_cfg(1'b0, 2'h3, 1'b0);
        request(1'b0, 2'h1);
        chk("fifo one partial", 10'h005,
            {7'h00, write_pointer_zero[0], fifo_ready[0], fifo_ready[1]});
        wait_ready(2'h3);
        check_kept;
        request(1'b0, 2'h2);
        chk("fifo two partial", 10'h005, {7'h00, write_pointer_zero[1], fifo_ready});
        wait_ready(2'h3);
        check_kept;
        // Full reset now relatches and clears fifo two offsets
        request(1'b1, 2'h0);
        wait_ready(2'h1);
        chk_m("method", fifo_reset_pkg::PROG_SERIAL, prog_method);
        chk("fifo two offsets", 10'h000, two_ae | two_af);
        // System reset in the middle of a full reset
        request(1'b1, 2'h0);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk("after system reset", 10'h000, {7'h00, endian_mode, fifo_ready});
        chk_m("method after system reset", fifo_reset_pkg::PROG_PRESET, prog_method);
        @(posedge clk);
        sys_rst <= 1'b0;
        wait_ready(2'h1);
        chk_m("method", fifo_reset_pkg::PROG_SERIAL, prog_method);
        finish_test;
    end
endmodule
